// ==== common/prot_map.svh ====
`ifndef PROT_MAP_SVH
`define PROT_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFF_CFG 8'h00
`define OFF_CMD 8'h04
`define OFF_STAT 8'h08
`define OFF_FEAT 8'h0c
`define OFF_PWD_BASE 4'h1

// ----------------------------------------------------------------
// configuration field positions and values
// ----------------------------------------------------------------
`define BIT_TRAP 13
`define BIT_WRAP 11
`define BIT_ECCSW 9
`define BIT_RDPWD 5
`define BIT_PWLOCK 2
`define BIT_PSLOCK 1
`define CFG_FACTORY 16'hfeff
`define CFG_PROG_MASK 16'h2a26
`define PWD_FACTORY 64'hffff_ffff_ffff_ffff

// ----------------------------------------------------------------
// status bit positions
// ----------------------------------------------------------------
`define ST_READY 7
`define ST_ERASE_FAIL 5
`define ST_PROG_FAIL 4
`define ST_LOCK_FAIL 1
`define ST_GUARD_LOCK 0

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define CMD_LOCK_CLEAR 16'h0001
`define CMD_PWD_PROG 16'h0002
`define CMD_UNLOCK 16'h0003
`define CMD_GUARD_PROG 16'h0004
`define CMD_GUARD_ERASE 16'h0005

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define UNLOCK_TIME_NS 100000
`define UNLOCK_CYCLES (`UNLOCK_TIME_NS / `CLK_PERIOD_NS)

`endif

// ==== common/prot_pkg.sv ====
package prot_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } fsm_t;

    typedef enum logic [4:0] {
        OP_CFG = 5'b00001,
        OP_PWD = 5'b00010,
        OP_UNLOCK = 5'b00100,
        OP_GPROG = 5'b01000,
        OP_GERASE = 5'b10000
    } op_t;

    typedef struct packed {
        fsm_t st;
        op_t op;
        logic [15:0] cnt;
        logic [15:0] cfg;
        logic [15:0] cfg_new;
        logic [63:0] pwd;
        logic [63:0] stage;
        logic [3:0] stage_vld;
        logic lock;
        logic f_prog;
        logic f_erase;
        logic f_lock;
        logic [15:0] rdata;
        logic hw_meta;
        logic hw_sync;
    } state_t;

endpackage

// ==== logic/protection_mode_password_lock.sv ====
// What this block does
// - bit 13 picks trap of single and double errors (0) or double only (1).
// - bit 11 picks hybrid burst (0) or wrapped-only burst (1, default).
// - bit 9 at 0 enables dual error detect, at 1 enables ecc switch.
// - bit 5 programmed to 0 permanently enables read-password option.
// - method field 01 password, 10 persistent, both frozen; 11 temporary persistent.
// - programming both method bits at once aborts with status bits 4 and 1.
// - any configuration program after a method bit is set aborts likewise.
// - each programmed method bit permanently excludes the other scheme.
// - once password method set, lock clears only by reset or lock command.
// - configuration program takes word-program time, visible via status reads.
// - persistent mode: reset sets lock, command clears it, nothing sets it.
// - password mode: reset clears lock, only matching unlock sets it.
// - password program only turns ones into zeros.
// - password is separate, factory all ones, any value valid.
// - after password method set, password reads hidden, programs fail.
// - password method bit can never be erased.
// - unlock words may arrive in any order before comparison.
// - mismatch fails with program-fail status bit 4 only, lock stays 0.
// - unlock takes the unlock interval, none accepted meanwhile.
// - guard bit program or erase with lock 0 times out and fails.
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "prot_map.svh"

module protection_mode_password_lock #(
    parameter logic [15:0] PROG_CYCLES = 16'd1000,
    parameter logic [15:0] ERASE_CYCLES = 16'd2000
) (
    input wire logic clk, // 25 mhz clock
    input wire logic reset_n, // power-on reset
    input wire logic hw_reset_n, // hardware reset pin
    input wire logic [7:0] addr, // register byte address
    input wire logic [15:0] wdata, // write data
    input wire logic wr_en, // write strobe
    input wire logic rd_en, // read strobe
    output logic [15:0] rdata, // read data, cycle after strobe
    output logic busy, // operation in progress
    output logic guard_lock, // 1 lets guard bits change
    output logic trap_double_only, // trap selection
    output logic wrap_only_burst, // burst selection
    output logic ecc_switch_en, // 0 means dual error detect
    output logic read_password_off, // 0 means read-password option on
    output logic password_mode_n, // 0 means password method
    output logic persistent_mode_n // 0 means persistent method frozen
);

    localparam logic [15:0] UNLOCK_CYC = 16'(`UNLOCK_CYCLES);

    prot_pkg::state_t q;
    prot_pkg::state_t d;

    function automatic logic [15:0] word_of(input logic [63:0] v, input logic [1:0] i);
        word_of = v[i*16 +: 16];
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [1:0] idx;
        logic pwd_hit;
        logic frozen;
        logic both;
        idx = addr[3:2];
        pwd_hit = (addr[7:4] == `OFF_PWD_BASE) && (addr[1:0] == 2'b00);
        frozen = q.cfg[2:1] != 2'b11;
        both = !wdata[`BIT_PWLOCK] && !wdata[`BIT_PSLOCK];
        d = q;
        d.hw_meta = hw_reset_n;
        d.hw_sync = q.hw_meta;
        d.rdata = 16'h0000;
        if (rd_en) begin
            if (addr == `OFF_CFG) begin
                d.rdata = q.cfg;
            end else if (addr == `OFF_STAT) begin
                d.rdata[`ST_READY] = q.st == prot_pkg::ST_IDLE;
                d.rdata[`ST_ERASE_FAIL] = q.f_erase;
                d.rdata[`ST_PROG_FAIL] = q.f_prog;
                d.rdata[`ST_LOCK_FAIL] = q.f_lock;
                d.rdata[`ST_GUARD_LOCK] = q.lock;
            end else if (addr == `OFF_FEAT) begin
                d.rdata[5:0] = {~q.cfg[`BIT_PSLOCK], ~q.cfg[`BIT_PWLOCK], ~q.cfg[`BIT_RDPWD],
                                ~q.cfg[`BIT_ECCSW], ~q.cfg[`BIT_WRAP], ~q.cfg[`BIT_TRAP]};
            end else if (pwd_hit && q.cfg[`BIT_PWLOCK]) begin
                d.rdata = word_of(q.pwd, idx);
            end
        end
        if (wr_en && addr == `OFF_STAT) begin
            d.f_prog = 1'b0;
            d.f_erase = 1'b0;
            d.f_lock = 1'b0;
        end
        case (q.st)
            prot_pkg::ST_IDLE: begin
                if (wr_en && addr == `OFF_CFG) begin
                    if (frozen || both) begin
                        d.f_prog = 1'b1;
                        d.f_lock = 1'b1;
                    end else begin
                        d.st = prot_pkg::ST_BUSY;
                        d.op = prot_pkg::OP_CFG;
                        d.cnt = PROG_CYCLES;
                        d.cfg_new = wdata;
                    end
                end else if (wr_en && pwd_hit) begin
                    d.stage[idx*16 +: 16] = wdata;
                    d.stage_vld[idx] = 1'b1;
                end else if (wr_en && addr == `OFF_CMD) begin
                    case (wdata)
                        `CMD_LOCK_CLEAR: begin
                            d.lock = 1'b0;
                        end
                        `CMD_PWD_PROG: begin
                            if (!q.cfg[`BIT_PWLOCK]) begin
                                d.f_prog = 1'b1;
                                d.f_lock = 1'b1;
                            end else begin
                                d.st = prot_pkg::ST_BUSY;
                                d.op = prot_pkg::OP_PWD;
                                d.cnt = PROG_CYCLES;
                            end
                        end
                        `CMD_UNLOCK: begin
                            if (q.cfg[2:1] != 2'b01 || q.stage_vld != 4'hf) begin
                                d.f_prog = 1'b1;
                            end else begin
                                d.st = prot_pkg::ST_BUSY;
                                d.op = prot_pkg::OP_UNLOCK;
                                d.cnt = UNLOCK_CYC;
                            end
                        end
                        `CMD_GUARD_PROG: begin
                            d.st = prot_pkg::ST_BUSY;
                            d.op = prot_pkg::OP_GPROG;
                            d.cnt = PROG_CYCLES;
                        end
                        `CMD_GUARD_ERASE: begin
                            d.st = prot_pkg::ST_BUSY;
                            d.op = prot_pkg::OP_GERASE;
                            d.cnt = ERASE_CYCLES;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            prot_pkg::ST_BUSY: begin
                if (q.cnt > 16'h0001) begin
                    d.cnt = q.cnt - 16'h0001;
                end else begin
                    d.st = prot_pkg::ST_IDLE;
                    d.cnt = 16'h0000;
                    case (q.op)
                        prot_pkg::OP_CFG: begin
                            // otp: bits only go from 1 to 0
                            d.cfg = q.cfg & (q.cfg_new | ~`CFG_PROG_MASK);
                        end
                        prot_pkg::OP_PWD: begin
                            for (int i = 0; i < 4; i++) begin
                                if (q.stage_vld[i]) begin
                                    d.pwd[i*16 +: 16] = q.pwd[i*16 +: 16] &
                                                        q.stage[i*16 +: 16];
                                end
                            end
                            d.stage_vld = 4'h0;
                        end
                        prot_pkg::OP_UNLOCK: begin
                            if (q.stage == q.pwd) begin
                                d.lock = 1'b1;
                            end else begin
                                d.f_prog = 1'b1;
                            end
                            d.stage_vld = 4'h0;
                        end
                        prot_pkg::OP_GPROG: begin
                            if (!q.lock) begin
                                d.f_prog = 1'b1;
                                d.f_lock = 1'b1;
                            end
                        end
                        prot_pkg::OP_GERASE: begin
                            if (!q.lock) begin
                                d.f_erase = 1'b1;
                                d.f_lock = 1'b1;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            default: begin
                d.st = prot_pkg::ST_IDLE;
            end
        endcase
        // hardware reset: lock follows method, nonvolatile bits kept
        if (!q.hw_sync) begin
            d.st = prot_pkg::ST_IDLE;
            d.cnt = 16'h0000;
            d.stage_vld = 4'h0;
            d.lock = q.cfg[`BIT_PWLOCK];
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q.st <= prot_pkg::ST_IDLE;
            q.op <= prot_pkg::OP_CFG;
            q.cnt <= 16'h0000;
            q.cfg <= `CFG_FACTORY;
            q.cfg_new <= 16'hffff;
            q.pwd <= `PWD_FACTORY;
            q.stage <= 64'h0000_0000_0000_0000;
            q.stage_vld <= 4'h0;
            q.lock <= 1'b1;
            q.f_prog <= 1'b0;
            q.f_erase <= 1'b0;
            q.f_lock <= 1'b0;
            q.rdata <= 16'h0000;
            q.hw_meta <= 1'b1;
            q.hw_sync <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign busy = q.st[1];
    assign guard_lock = q.lock;
    assign trap_double_only = q.cfg[`BIT_TRAP];
    assign wrap_only_burst = q.cfg[`BIT_WRAP];
    assign ecc_switch_en = q.cfg[`BIT_ECCSW];
    assign read_password_off = q.cfg[`BIT_RDPWD];
    assign password_mode_n = q.cfg[`BIT_PWLOCK];
    assign persistent_mode_n = q.cfg[`BIT_PSLOCK];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [15:0] busy_len;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_len <= 16'h0000;
        end else if (q.st == prot_pkg::ST_BUSY) begin
            busy_len <= busy_len + 16'h0001;
        end else begin
            busy_len <= 16'h0000;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // ----------------------------------------------------------------
    // checks: configuration
    // ----------------------------------------------------------------
    a_cfg_frozen: assert property ((q.cfg[2:1] != 2'b11) |=> q.cfg == $past(q.cfg))
        else $error("configuration changed after method frozen");

    a_cfg_abort: assert property ((q.st == prot_pkg::ST_IDLE && q.hw_sync && wr_en &&
            addr == `OFF_CFG && q.cfg[2:1] != 2'b11) |=> q.f_prog && q.f_lock && !busy)
        else $error("frozen configuration program not aborted");

    a_both_bits: assert property ((q.st == prot_pkg::ST_IDLE && q.hw_sync && wr_en &&
            addr == `OFF_CFG && wdata[2:1] == 2'b00) |=> q.f_prog && q.f_lock)
        else $error("double method program not aborted");

    a_cfg_accept: assert property ((q.st == prot_pkg::ST_IDLE && q.hw_sync && wr_en &&
            addr == `OFF_CFG && q.cfg[2:1] == 2'b11 && wdata[2:1] != 2'b00) |=> busy)
        else $error("configuration program not started");

    a_cfg_time: assert property ($fell(busy) && $past(q.op) == prot_pkg::OP_CFG &&
            q.hw_sync |-> $past(busy_len) == PROG_CYCLES - 16'h0001)
        else $error("configuration program time wrong");

    a_otp_ones: assert property (1'b1 |=> (q.cfg & ~$past(q.cfg)) == 16'h0000)
        else $error("configuration bit went from zero to one");

    a_hw_idle: assert property ((!q.hw_sync) |=> !busy)
        else $error("busy during hardware reset");

    // ----------------------------------------------------------------
    // checks: password
    // ----------------------------------------------------------------
    a_pwd_ones: assert property (1'b1 |=> (q.pwd & ~$past(q.pwd)) == 64'h0)
        else $error("password bit went from zero to one");

    a_pwd_hidden: assert property ((rd_en && addr[7:4] == `OFF_PWD_BASE && !q.cfg[2]) |=>
            rdata == 16'h0000)
        else $error("password readable after lock");

    a_pwd_frozen: assert property ((!q.cfg[`BIT_PWLOCK]) |=> q.pwd == $past(q.pwd))
        else $error("password changed after method lock");

    a_pwd_abort: assert property ((q.st == prot_pkg::ST_IDLE && q.hw_sync && wr_en &&
            addr == `OFF_CMD && wdata == `CMD_PWD_PROG && !q.cfg[2]) |=> q.f_prog && !busy)
        else $error("locked password program not aborted");

    a_pwd_accept: assert property ((q.st == prot_pkg::ST_IDLE && q.hw_sync && wr_en &&
            addr == `OFF_CMD && wdata == `CMD_PWD_PROG && q.cfg[2]) |=> busy)
        else $error("password program not started");

    a_pwd_time: assert property ($fell(busy) && $past(q.op) == prot_pkg::OP_PWD &&
            q.hw_sync |-> $past(busy_len) == PROG_CYCLES - 16'h0001)
        else $error("password program time wrong");

    a_stage_clear: assert property ($fell(busy) && q.hw_sync && ($past(q.op) == prot_pkg::OP_PWD
            || $past(q.op) == prot_pkg::OP_UNLOCK) |-> q.stage_vld == 4'h0)
        else $error("staged words kept after use");

    // ----------------------------------------------------------------
    // checks: lock
    // ----------------------------------------------------------------
    a_lock_rise: assert property ($rose(q.lock) && q.hw_sync |->
            $past(q.op) == prot_pkg::OP_UNLOCK && $past(busy) && !q.cfg[`BIT_PWLOCK])
        else $error("lock set without unlock");

    a_persist_hold: assert property ((!q.lock && q.cfg[2:1] == 2'b10 && q.hw_sync) |=>
            !q.lock)
        else $error("persistent lock set by command");

    a_lock_clear: assert property ((q.st == prot_pkg::ST_IDLE && q.hw_sync && wr_en &&
            addr == `OFF_CMD && wdata == `CMD_LOCK_CLEAR) |=> !q.lock)
        else $error("lock clear command ignored");

    a_hw_lock_mode: assert property ((!q.hw_sync) |=> q.lock == $past(q.cfg[`BIT_PWLOCK]))
        else $error("hardware reset left lock wrong");

    a_unlock_start: assert property ((q.st == prot_pkg::ST_IDLE && q.hw_sync && wr_en &&
            addr == `OFF_CMD && wdata == `CMD_UNLOCK && q.cfg[2:1] == 2'b01 &&
            q.stage_vld == 4'hf) |=> busy && q.op == prot_pkg::OP_UNLOCK)
        else $error("unlock not started");

    a_unlock_refuse: assert property ((q.st == prot_pkg::ST_IDLE && q.hw_sync && wr_en &&
            addr == `OFF_CMD && wdata == `CMD_UNLOCK && q.cfg[2:1] != 2'b01) |=>
            q.f_prog && !busy)
        else $error("unlock outside password method not failed");

    a_unlock_time: assert property ($fell(busy) && $past(q.op) == prot_pkg::OP_UNLOCK |->
            $past(busy_len) == UNLOCK_CYC - 16'h0001)
        else $error("unlock interval wrong");

    a_mismatch: assert property ($fell(busy) && q.hw_sync && $past(q.op) == prot_pkg::OP_UNLOCK
            && $past(q.stage) != $past(q.pwd) |-> q.f_prog && !q.lock)
        else $error("mismatch did not fail");

    a_unlock_match: assert property ($fell(busy) && q.hw_sync && $past(q.op) == prot_pkg::OP_UNLOCK
            && $past(q.stage) == $past(q.pwd) |-> q.lock)
        else $error("matching password did not unlock");

    // ----------------------------------------------------------------
    // checks: guard bits
    // ----------------------------------------------------------------
    a_guard_start: assert property ((q.st == prot_pkg::ST_IDLE && q.hw_sync && wr_en &&
            addr == `OFF_CMD && wdata == `CMD_GUARD_PROG) |=> busy)
        else $error("guard program not started");

    a_guard_fail: assert property ($fell(busy) && q.hw_sync && $past(q.op) == prot_pkg::OP_GPROG
            && !$past(q.lock) |-> q.f_prog && q.f_lock)
        else $error("guard program with lock 0 not failed");

    a_erase_fail: assert property ($fell(busy) && q.hw_sync && $past(q.op) == prot_pkg::OP_GERASE
            && !$past(q.lock) |-> q.f_erase && q.f_lock)
        else $error("guard erase with lock 0 not failed");

    a_erase_time: assert property ($fell(busy) && $past(q.op) == prot_pkg::OP_GERASE &&
            q.hw_sync |-> $past(busy_len) == ERASE_CYCLES - 16'h0001)
        else $error("guard erase time wrong");

endmodule

// ==== test/flash_host.sv ====
`timescale 1ns/10ps
`include "prot_map.svh"

module flash_host (
    input wire logic clk, // bus clock
    output logic [7:0] addr, // register address
    output logic [15:0] wdata, // write data
    output logic wr_en, // write strobe
    output logic rd_en // read strobe
);
    initial begin
        addr = 8'h00;
        wdata = 16'h0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end

    // ----------------------------------------------------------------
    // bus cycles, one idle cycle after each strobe
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // password words, index order unless rev
    // ----------------------------------------------------------------
    task automatic stage(input logic [63:0] v, input bit rev);
        int j;
        for (int i = 0; i < 4; i++) begin
            j = rev ? 3 - i : i;
            wr(8'h10 + 8'(4 * j), v[16 * j +: 16]);
        end
    endtask

    task automatic prog_pwd(input logic [63:0] v);
        stage(v, 1'b0);
        wr(`OFF_CMD, `CMD_PWD_PROG);
    endtask
endmodule

// ==== test/tb.sv ====
`timescale 1ns/10ps
`include "prot_map.svh"

`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_errors++; \
    $display("wrong value %s expected %h seen %h", nm, e, s); end end

module tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic hw_reset_n = 1'b1;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, e_now;
    logic wr_en, rd_en, busy, guard_lock, trap_double_only, wrap_only_burst;
    logic ecc_switch_en, read_password_off, password_mode_n, persistent_mode_n;
    logic rd_seen = 1'b0;
    logic [63:0] pw, pw2;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    int n;
    integer seed = 32'h0ce8e462;
    logic [15:0] exp_q[$];
    string nm_q[$];
    string n_now;

    always #20 clk = ~clk;

    flash_host HOST (.clk, .addr, .wdata, .wr_en, .rd_en);

    protection_mode_password_lock #(.PROG_CYCLES(16'd4), .ERASE_CYCLES(16'd4)) DUT (
        .clk, .reset_n, .hw_reset_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .busy,
        .guard_lock, .trap_double_only, .wrap_only_burst, .ecc_switch_en,
        .read_password_off, .password_mode_n, .persistent_mode_n);

    // ----------------------------------------------------------------
    // read data monitor
    // ----------------------------------------------------------------
    always @(posedge clk) rd_seen <= rd_en;
    always @(negedge clk) begin
        if (rd_seen && exp_q.size() > 0) begin
            e_now = exp_q.pop_front();
            n_now = nm_q.pop_front();
            `CHK(n_now, e_now, rdata)
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 12000) begin
            n_errors++;
            close_out;
        end
    end

    task automatic rc(input logic [7:0] a, input logic [15:0] e, input string nm);
        exp_q.push_back(e);
        nm_q.push_back(nm);
        HOST.rd(a);
    endtask

    task automatic idle(output int k);
        k = 0;
        @(negedge clk);
        while (busy === 1'b1 && k < 3000) begin
            k++;
            @(negedge clk);
        end
    endtask

    task automatic cmd(input logic [15:0] c);
        HOST.wr(`OFF_CMD, c);
    endtask

    task automatic clr;
        HOST.wr(`OFF_STAT, 16'h0000);
    endtask

    task automatic hw_rst;
        @(posedge clk) hw_reset_n <= 1'b0;
        repeat (4) @(posedge clk);
        hw_reset_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        rc(`OFF_CFG, 16'hfeff, "cfg");
        rc(`OFF_FEAT, 16'h0000, "features");
        rc(`OFF_STAT, 16'h0081, "status");
        rc(8'h10, 16'hffff, "pwd word");
        $display("test reset done");
        pw = {$random(seed), $random(seed)};
        HOST.prog_pwd(pw);
        idle(n);
        pw2 = {$random(seed), $random(seed)};
        HOST.prog_pwd(pw2);
        idle(n);
        pw = pw & pw2;
        for (int i = 0; i < 4; i++) rc(8'h10 + 8'(4 * i), pw[16 * i +: 16], "pwd");
        $display("test password program done");
        HOST.wr(`OFF_CFG, 16'hd5df);
        idle(n);
        `CHK("cfg busy", 1'b1, 1'(n >= 2 && n <= 4))
        rc(`OFF_CFG, 16'hd4df, "cfg");
        rc(`OFF_FEAT, 16'h000f, "features");
        `CHK("trap", 1'b0, trap_double_only)
        `CHK("wrap", 1'b0, wrap_only_burst)
        `CHK("ecc switch", 1'b0, ecc_switch_en)
        `CHK("read pwd off", 1'b0, read_password_off)
        `CHK("persistent n", 1'b1, persistent_mode_n)
        HOST.wr(`OFF_CFG, 16'hfff9);
        rc(`OFF_STAT, 16'h0093, "status");
        rc(`OFF_CFG, 16'hd4df, "cfg");
        clr;
        $display("test configuration done");
        cmd(`CMD_UNLOCK);
        rc(`OFF_STAT, 16'h0091, "status");
        clr;
        cmd(`CMD_LOCK_CLEAR);
        rc(`OFF_STAT, 16'h0080, "status");
        `CHK("guard lock", 1'b0, guard_lock)
        cmd(`CMD_GUARD_PROG);
        idle(n);
        rc(`OFF_STAT, 16'h0092, "status");
        clr;
        cmd(`CMD_GUARD_ERASE);
        idle(n);
        rc(`OFF_STAT, 16'h00a2, "status");
        clr;
        hw_rst;
        `CHK("guard lock", 1'b1, guard_lock)
        $display("test persistent done");
        HOST.wr(`OFF_CFG, 16'hfffb);
        idle(n);
        `CHK("password n", 1'b0, password_mode_n)
        `CHK("persistent n", 1'b1, persistent_mode_n)
        hw_rst;
        `CHK("guard lock", 1'b0, guard_lock)
        HOST.wr(`OFF_CFG, 16'hfffd);
        rc(`OFF_STAT, 16'h0092, "status");
        rc(`OFF_CFG, 16'hd4db, "cfg");
        clr;
        rc(8'h10, 16'h0000, "pwd word");
        HOST.prog_pwd(~pw);
        rc(`OFF_STAT, 16'h0092, "status");
        clr;
        $display("test password method done");
        HOST.stage(pw ^ 64'h1, 1'b1);
        cmd(`CMD_UNLOCK);
        cmd(`CMD_UNLOCK);
        idle(n);
        `CHK("unlock busy", 1'b1, 1'(n >= 2493 && n <= 2498))
        rc(`OFF_STAT, 16'h0090, "status");
        clr;
        HOST.stage(pw, 1'b1);
        cmd(`CMD_UNLOCK);
        idle(n);
        `CHK("guard lock", 1'b1, guard_lock)
        rc(`OFF_STAT, 16'h0081, "status");
        cmd(`CMD_LOCK_CLEAR);
        rc(`OFF_STAT, 16'h0080, "status");
        $display("test unlock done");
        @(posedge clk) reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        HOST.wr(`OFF_CFG, 16'hfffd);
        idle(n);
        `CHK("persistent n", 1'b0, persistent_mode_n)
        cmd(`CMD_LOCK_CLEAR);
        cmd(`CMD_UNLOCK);
        rc(`OFF_STAT, 16'h0090, "status");
        `CHK("guard lock", 1'b0, guard_lock)
        HOST.wr(`OFF_CFG, 16'hfffb);
        rc(`OFF_STAT, 16'h0092, "status");
        rc(`OFF_CFG, 16'hfefd, "cfg");
        hw_rst;
        `CHK("guard lock", 1'b1, guard_lock)
        $display("test power cycle done");
        close_out;
    end
endmodule
